// [bench/testbench.sv]
// Self-checking bench for the two-channel mode and map logic.
// Assumes the line model drives the serial side; core bytes held steady.
`timescale 1ns/1ps
module testbench;
  reg         ref_clk        = 1'b0;
  reg         rst            = 1'b1;
  reg         chip_select_n  = 1'b1;
  reg         channel_select = 1'b0;
  reg  [2:0]  addr           = 3'h0;
  reg         wr_strobe      = 1'b0;
  reg         rd_strobe      = 1'b0;
  reg  [7:0]  wr_data        = 8'h00;
  reg  [1:0]  tx_shift_out   = 2'b11;
  reg  [1:0]  start_req      = 2'b00;
  reg         modem_poke     = 1'b0;
  reg  [7:0]  q;
  wire [7:0]  rd_data;
  wire [7:0]  modem_in_n;
  wire [1:0]  rx_pin, baud_tick16, tx_pin, rts_n, dtr_n, rx_shift_in, tx_hold_write;
  wire [1:0]  rx_hold_read, fifo_ctrl_write;
  wire [15:0] tx_hold_data, modem_status, divisor_word_a, divisor_word_b;
  wire        osc_run;
  integer     failures     = 0;
  integer     total_checks = 0;
  integer     n;
  reg  [7:0]  rhr_pulses   = 8'h00;
  reg  [7:0]  fcw_pulses   = 8'h00;

  always #25 ref_clk = ~ref_clk;

  uisl_line_model uisl_line_model_i (.ref_clk(ref_clk), .start_req(start_req), .modem_poke(modem_poke),
    .rx_pin(rx_pin), .baud_tick16(baud_tick16), .modem_in_n(modem_in_n));
  uisl_top uisl_top_i (.ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n), .channel_select(channel_select),
    .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data), .rd_data(rd_data),
    .baud_tick16(baud_tick16), .tx_shift_out(tx_shift_out), .rx_pin(rx_pin), .modem_in_n(modem_in_n),
    .rx_hold_byte(16'h3132), .fifo_level(16'h0d0c), .line_status_in(16'h6261), .status_in(16'h0101),
    .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n), .rx_shift_in(rx_shift_in), .tx_hold_write(tx_hold_write),
    .rx_hold_read(rx_hold_read), .fifo_ctrl_write(fifo_ctrl_write), .tx_hold_data(tx_hold_data),
    .modem_status(modem_status), .divisor_word_a(divisor_word_a), .divisor_word_b(divisor_word_b),
    .osc_run(osc_run));

  // Count one-cycle decode pulses of both channels
  always @(posedge ref_clk) begin
    rhr_pulses <= rhr_pulses + {7'h00, rx_hold_read[0]} + {7'h00, rx_hold_read[1]};
    fcw_pulses <= fcw_pulses + {7'h00, fifo_ctrl_write[0]} + {7'h00, fifo_ctrl_write[1]};
  end

  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One access taken at the next edge; read data two cycles on
  task bus(input w, input ch, input [2:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      chip_select_n <= 1'b0;
      channel_select <= ch;
      addr <= a;
      wr_strobe <= w;
      rd_strobe <= !w;
      wr_data <= d;
      @(posedge ref_clk);
      chip_select_n <= 1'b1;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      q = rd_data;
    end
  endtask
  task wr(input ch, input [2:0] a, input [7:0] d);
    bus(1'b1, ch, a, d);
  endtask
  task rdchk(input ch, input [2:0] a, input [7:0] exp);
    begin
      bus(1'b0, ch, a, 8'h00);
      chk(q, exp);
    end
  endtask
  task wait_osc(input v);
    begin
      n = 0;
      while (osc_run !== v && n < 20) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk({7'h00, osc_run}, {7'h00, v});
    end
  endtask
  // High cycles of channel a transmit pin over two bit cells, after 20 settling cycles
  task count_high;
    integer i;
    begin
      repeat (20) @(negedge ref_clk);
      n = 0;
      for (i = 0; i < 32; i = i + 1) begin
        @(negedge ref_clk);
        n = n + tx_pin[0];
      end
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_pages(input ch);
    begin
      rdchk(ch, 3'h3, 8'h03);
      wr(ch, 3'h1, 8'hff);
      rdchk(ch, 3'h1, 8'h0f);
      wr(ch, 3'h3, 8'h80);
      rdchk(ch, 3'h0, 8'h01);
      wr(ch, 3'h2, 8'h77);
      rdchk(ch, 3'h2, 8'h77);
      wr(ch, 3'h0, 8'h00);
      wr(ch, 3'h1, 8'h00);
      chk(ch ? divisor_word_b[7:0] : divisor_word_a[7:0], 8'h00);
      rdchk(ch, 3'h0, 8'h5a);
      rdchk(ch, 3'h1, 8'ha5);
      wr(ch, 3'h3, 8'hbf);
      wr(ch, 3'h2, 8'h10);
      wr(ch, 3'h1, 8'h04);
      rdchk(ch, 3'h1, 8'h04);
      wr(ch, 3'h3, 8'h03);
      wr(ch, 3'h5, 8'hff);
      rdchk(ch, 3'h5, ch ? 8'h62 : 8'h61);
      rdchk(ch, 3'h2, 8'h01);
      wr(ch, 3'h2, 8'h07);
      chk(fcw_pulses, ch ? 8'h02 : 8'h01);
      rdchk(ch, 3'h0, ch ? 8'h31 : 8'h32);
      chk(rhr_pulses, ch ? 8'h02 : 8'h01);
      wr(ch, 3'h7, 8'h3c);
      rdchk(ch, 3'h7, ch ? 8'h0d : 8'h0c);
      wr(ch, 3'h0, 8'hc3);
      chk(tx_hold_data[8*ch +: 8], 8'hc3);
    end
  endtask
  task t_loop;
    begin
      wr(1'b0, 3'h4, 8'h13);
      @(posedge ref_clk);
      tx_shift_out <= 2'b10;
      modem_poke <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({5'h00, tx_pin[0], rts_n[0], dtr_n[0]}, 8'h07);
      chk({7'h00, rx_shift_in[0]}, 8'h00);
      chk(modem_status[7:0], 8'h00);
      rdchk(1'b0, 3'h3, 8'h03);
      @(posedge ref_clk);
      tx_shift_out <= 2'b11;
      modem_poke <= 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({7'h00, rx_shift_in[0]}, 8'h01);
      wr(1'b0, 3'h4, 8'h00);
    end
  endtask
  task t_ir;
    begin
      wr(1'b0, 3'h4, 8'h40);
      @(posedge ref_clk);
      tx_shift_out <= 2'b10;
      count_high;
      chk(n[7:0], 8'h06);
      chk({7'h00, rx_shift_in[0]}, 8'h01);
      @(posedge ref_clk);
      tx_shift_out <= 2'b11;
      count_high;
      chk(n[7:0], 8'h00);
      wr(1'b0, 3'h4, 8'h00);
      count_high;
      chk(n[7:0], 8'h20);
      chk({7'h00, rx_shift_in[0]}, 8'h00);
    end
  endtask
  task t_sleep;
    begin
      wr(1'b0, 3'h1, 8'h10);
      wr(1'b1, 3'h1, 8'h10);
      wait_osc(1'b0);
      @(posedge ref_clk);
      start_req <= 2'b01;
      @(posedge ref_clk);
      start_req <= 2'b00;
      wait_osc(1'b1);
      wait_osc(1'b0);
      wr(1'b0, 3'h0, 8'h55);
      wait_osc(1'b1);
      wait_osc(1'b0);
      @(posedge ref_clk);
      modem_poke <= 1'b1;
      @(posedge ref_clk);
      modem_poke <= 1'b0;
      wait_osc(1'b1);
      repeat (10) @(negedge ref_clk);
      chk({7'h00, osc_run}, 8'h01);
      chk(modem_status[7:0], 8'h01);
      rdchk(1'b0, 3'h6, 8'h01);
      wait_osc(1'b0);
      @(posedge ref_clk);
      modem_poke <= 1'b1;
      @(posedge ref_clk);
      modem_poke <= 1'b0;
      wait_osc(1'b1);
      wr(1'b0, 3'h1, 8'h00);
      rdchk(1'b0, 3'h6, 8'h01);
      repeat (10) @(negedge ref_clk);
      chk({7'h00, osc_run}, 8'h01);
    end
  endtask

  task wrap_up;
    begin
      if (failures == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    failures = failures + 1;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_pages(1'b0);
    t_pages(1'b1);
    t_loop;
    t_ir;
    t_sleep;
    wrap_up;
  end
endmodule // testbench

// [bench/uisl_line_model.sv]
// Far-side line model: serial receive lines, modem inputs and baud ticks.
// Assumes the bench requests start edges and modem changes on ref_clk.
`timescale 1ns/1ps
module uisl_line_model (
  input  wire       ref_clk,
  input  wire [1:0] start_req,
  input  wire       modem_poke,
  output reg  [1:0] rx_pin,
  output reg  [1:0] baud_tick16,
  output reg  [7:0] modem_in_n
);
  initial begin
    rx_pin = 2'b11;
    baud_tick16 = 2'b00;
    modem_in_n = 8'hff;
  end
  // Lines rest at mark; start bit and modem change only on request
  always @(posedge ref_clk) begin
    rx_pin      <= ~start_req;
    baud_tick16 <= 2'b11;
    modem_in_n  <= {7'h7f, ~modem_poke};
  end
endmodule // uisl_line_model

// [bench/uisl_top_monitor.sv]
// Checker of transmit write pulses, read timing and sleep entry and exit.
// Assumes binding to uisl_top; sees its ports only.
`timescale 1ns/1ps
module uisl_top_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        chip_select_n,
  input wire        channel_select,
  input wire [2:0]  addr,
  input wire        wr_strobe,
  input wire        rd_strobe,
  input wire [7:0]  rd_data,
  input wire [1:0]  rx_pin,
  input wire [7:0]  modem_in_n,
  input wire [15:0] status_in,
  input wire [1:0]  tx_hold_write,
  input wire        osc_run
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Oscillator stopped
  sequence s_asleep;
    !osc_run;
  endsequence
  a_hold_cause_a: assert property (tx_hold_write[0] |-> $past(wr_strobe && !chip_select_n && !channel_select && addr == 3'h0))
    else $error("transmit write pulse on channel a without a take");
  a_hold_cause_b: assert property (tx_hold_write[1] |-> $past(wr_strobe && !chip_select_n && channel_select && addr == 3'h0))
    else $error("transmit write pulse on channel b without a take");
  a_read_data_late: assert property (rd_data != 8'h00 |-> $past(rd_strobe && !chip_select_n, 2))
    else $error("read data without a read two cycles before");
  a_wake_rx_edge: assert property (s_asleep ##0 $fell(rx_pin[0]) |-> ##[1:3] osc_run)
    else $error("no wake after start edge");
  a_wake_tx_write: assert property (s_asleep ##0 tx_hold_write[0] |-> ##[1:3] osc_run)
    else $error("no wake after transmit write");
  a_wake_modem_change: assert property (s_asleep ##0 (modem_in_n != $past(modem_in_n)) |-> ##[1:3] osc_run)
    else $error("no wake after modem change");
  a_sleep_no_int: assert property ($fell(osc_run) |-> $past(status_in[0] && status_in[8], 2))
    else $error("sleep entered with interrupt pending");
  a_sleep_rx_idle: assert property ($fell(osc_run) |-> $past(rx_pin, 2) == 2'b11 && $past(rx_pin, 3) == 2'b11)
    else $error("sleep entered with receive line not idle");
endmodule // uisl_top_monitor
bind uisl_top uisl_top_monitor mon_i (.ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
  .channel_select(channel_select), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
  .rx_pin(rx_pin), .modem_in_n(modem_in_n), .status_in(status_in), .tx_hold_write(tx_hold_write), .osc_run(osc_run));

// [logic/uisl_channel.v]
// One channel's register page decode, infrared codec, loopback and sleep votes.
// Assumes a synchronous host bus on ref_clk; core tx and rx logic sits outside.
`timescale 1ns/1ps
`include "uisl_regs.vh"

module uisl_channel #(
  parameter [7:0] REVISION_CODE = 8'h5a, // Arbitrary value
  parameter [7:0] IDENT_CODE    = 8'ha5  // Arbitrary value
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       chip_select_n,
  input  wire       channel_select,
  input  wire       my_channel,
  input  wire [2:0] addr,
  input  wire       wr_strobe,
  input  wire       rd_strobe,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output reg        tx_hold_write,
  output reg        rx_hold_read,
  output reg        fifo_ctrl_write,
  output reg  [7:0] tx_hold_data,
  input  wire [7:0] rx_hold_byte,
  input  wire [7:0] fifo_level,
  input  wire [7:0] line_status_in,
  input  wire [7:0] status_in,
  input  wire       baud_tick16,
  input  wire       tx_shift_out,
  input  wire       rx_pin,
  input  wire [3:0] modem_in_n,
  output reg        tx_pin,
  output reg        rts_n,
  output reg        dtr_n,
  output reg        rx_shift_in,
  output reg  [7:0] modem_status,
  output reg  [7:0] divisor_low_byte,
  output reg  [7:0] divisor_high_byte,
  output reg        sleep_vote,
  output reg        wake_event
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [7:0] line_control;
  reg [7:0] modem_control;
  reg [7:0] interrupt_enable;
  reg [7:0] feature_control;
  reg [7:0] enhanced_function;
  reg [7:0] alternate_function;
  reg [7:0] scratch_pad;
  reg [7:0] enhanced_mode_select;
  reg [7:0] fifo_trigger_level_set;
  reg [7:0] flow_char [0:3];
  reg [3:0] modem_last;
  reg       rx_last;
  reg [3:0] ir_tick;
  reg       ir_bit_zero;
  reg       ir_rx_q;
  reg [3:0] ir_rx_cnt;

  wire       sel      = ~chip_select_n & (channel_select == my_channel);
  wire       do_wr    = sel & wr_strobe;
  wire       do_rd    = sel & rd_strobe;
  wire       page_enh = (line_control == `UISL_ENH_PAGE);
  wire       page_div = line_control[`UISL_LCR_DIV_BIT] & ~page_enh;
  wire       page_base = ~line_control[`UISL_LCR_DIV_BIT];
  wire       enh_ok   = enhanced_function[`UISL_EFR_ENH_BIT];
  wire       ir_mode  = modem_control[`UISL_MCR_IR_BIT];
  wire       loop_mode = modem_control[`UISL_MCR_LOOP_BIT];
  // Loopback shows the modem inputs as inactive
  wire [3:0] modem_live = loop_mode ? 4'hf : modem_in_n;
  wire       rx_norm  = rx_pin ^ feature_control[`UISL_FEATURE_CONTROL_INV_BIT];
  wire       div_zero = (divisor_low_byte == 8'h00) && (divisor_high_byte == 8'h00);

  // Keep enhanced bits unchanged unless unlocked
  function [7:0] uisl_gate;
    input [7:0] newv;
    input [7:0] oldv;
    input [7:0] mask;
    input       ok;
    begin
      uisl_gate = ok ? newv : ((newv & ~mask) | (oldv & mask));
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_control <= `UISL_RST_LCR;
      modem_control <= `UISL_RST_BYTE;
      interrupt_enable <= `UISL_RST_BYTE;
      feature_control <= `UISL_RST_BYTE;
      enhanced_function <= `UISL_RST_BYTE;
      alternate_function <= `UISL_RST_BYTE;
      scratch_pad <= `UISL_RST_BYTE;
      enhanced_mode_select <= `UISL_RST_BYTE;
      fifo_trigger_level_set <= `UISL_RST_BYTE;
      divisor_low_byte <= `UISL_RST_DLL;
      divisor_high_byte <= `UISL_RST_BYTE;
      flow_char[0] <= `UISL_RST_BYTE;
      flow_char[1] <= `UISL_RST_BYTE;
      flow_char[2] <= `UISL_RST_BYTE;
      flow_char[3] <= `UISL_RST_BYTE;
      tx_hold_data <= `UISL_RST_BYTE;
      tx_hold_write <= 1'b0;
      fifo_ctrl_write <= 1'b0;
    end else begin
      tx_hold_write <= 1'b0;
      fifo_ctrl_write <= 1'b0;
      if (do_wr) begin
        case (addr)
          `UISL_OFS_DATA: begin
            if (page_enh) fifo_trigger_level_set <= wr_data;
            else if (page_div) divisor_low_byte <= wr_data;
            else begin
              tx_hold_data <= wr_data;
              tx_hold_write <= 1'b1;
            end
          end
          `UISL_OFS_IER: begin
            if (page_enh) feature_control <= wr_data;
            else if (page_div) divisor_high_byte <= wr_data;
            else interrupt_enable <= uisl_gate(wr_data, interrupt_enable, `UISL_IER_ENH_MASK, enh_ok);
          end
          `UISL_OFS_ISR: begin
            if (page_enh) enhanced_function <= wr_data;
            else if (page_div) alternate_function <= wr_data;
            else fifo_ctrl_write <= 1'b1;
          end
          `UISL_OFS_LCR: line_control <= wr_data;
          `UISL_OFS_MCR: begin
            if (page_enh) flow_char[0] <= wr_data;
            else modem_control <= uisl_gate(wr_data, modem_control, `UISL_MCR_ENH_MASK, enh_ok);
          end
          `UISL_OFS_LSR: begin
            if (page_enh) flow_char[1] <= wr_data;
          end
          `UISL_OFS_MSR: begin
            if (page_enh) flow_char[2] <= wr_data;
          end
          default: begin
            if (page_enh) flow_char[3] <= wr_data;
            else if (feature_control[`UISL_FEATURE_CONTROL_EMS_BIT]) enhanced_mode_select <= wr_data;
            else scratch_pad <= wr_data;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [7:0] next_rd_data;
  always @* begin
    next_rd_data = 8'h00;
    case (addr)
      `UISL_OFS_DATA: begin
        if (page_enh) next_rd_data = fifo_level;
        else if (page_div) next_rd_data = div_zero ? REVISION_CODE : divisor_low_byte;
        else next_rd_data = rx_hold_byte;
      end
      `UISL_OFS_IER: begin
        if (page_enh) next_rd_data = feature_control;
        else if (page_div) next_rd_data = div_zero ? IDENT_CODE : divisor_high_byte;
        else next_rd_data = enh_ok ? interrupt_enable : (interrupt_enable & ~`UISL_IER_ENH_MASK);
      end
      `UISL_OFS_ISR: begin
        if (page_enh) next_rd_data = enhanced_function;
        else if (page_div) next_rd_data = alternate_function;
        else next_rd_data = status_in;
      end
      `UISL_OFS_LCR: next_rd_data = line_control;
      `UISL_OFS_MCR: next_rd_data = page_enh ? flow_char[0] :
                       (enh_ok ? modem_control : (modem_control & ~`UISL_MCR_ENH_MASK));
      `UISL_OFS_LSR: next_rd_data = page_enh ? flow_char[1] : line_status_in;
      `UISL_OFS_MSR: next_rd_data = page_enh ? flow_char[2] : modem_status;
      default:       next_rd_data = page_enh ? flow_char[3] : fifo_level;
    endcase
  end

  // Registered read data and read strobe
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      rx_hold_read <= 1'b0;
    end else begin
      rd_data <= do_rd ? next_rd_data : 8'h00;
      rx_hold_read <= do_rd & page_base & (addr == `UISL_OFS_DATA);
    end
  end

  // ----------------------------------------------------------------
  // Modem status with sticky deltas, cleared by read
  // ----------------------------------------------------------------
  wire msr_read = do_rd & ~page_enh & (addr == `UISL_OFS_MSR);
  wire [3:0] delta_now = modem_live ^ modem_last;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      modem_last <= 4'hf;
      modem_status <= 8'h00;
      rx_last <= 1'b1;
    end else begin
      modem_last <= modem_live;
      rx_last <= rx_pin;
      modem_status[7:4] <= ~modem_live;
      // New change wins over the clearing read
      modem_status[3:0] <= (msr_read ? 4'h0 : modem_status[3:0]) | delta_now;
    end
  end

  // ----------------------------------------------------------------
  // Infrared encoder, decoder and loopback routing
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ir_tick <= 4'h0;
      ir_bit_zero <= 1'b0;
      ir_rx_q <= 1'b0;
      ir_rx_cnt <= 4'h0;
      tx_pin <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      rx_shift_in <= 1'b1;
    end else begin
      // Last tick of a cell latches the next bit; pulse covers ticks 0 to 2
      if (baud_tick16) begin
        ir_tick <= ir_tick + 4'h1;
        if (ir_tick == `UISL_TICKS_BIT) ir_bit_zero <= ~tx_shift_out;
      end
      // Hold received pulse high for one bit cell
      ir_rx_q <= rx_norm;
      if (rx_norm) ir_rx_cnt <= `UISL_TICKS_BIT;
      else if (baud_tick16 && ir_rx_cnt != 4'h0) ir_rx_cnt <= ir_rx_cnt - 4'h1;
      if (loop_mode) tx_pin <= 1'b1;
      else if (ir_mode) tx_pin <= ir_bit_zero && (ir_tick < `UISL_IR_PULSE);
      else tx_pin <= tx_shift_out;
      rts_n <= loop_mode ? 1'b1 : ~modem_control[`UISL_MCR_RTS_BIT];
      dtr_n <= loop_mode ? 1'b1 : ~modem_control[`UISL_MCR_DTR_BIT];
      if (loop_mode) rx_shift_in <= tx_shift_out;
      else if (ir_mode) rx_shift_in <= ~(ir_rx_q | (ir_rx_cnt != 4'h0));
      else rx_shift_in <= rx_norm;
    end
  end

  // ----------------------------------------------------------------
  // Sleep vote and wake events
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_vote <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      // Line counts as idle only when high on this and the last sample,
      // so the low cell of a start bit is never taken for idle
      sleep_vote <= status_in[0] & interrupt_enable[`UISL_IER_SLEEP_BIT] & enh_ok
                    & (modem_status[3:0] == 4'h0)
                    & rx_pin & rx_last;
      wake_event <= (rx_last & ~rx_pin) | tx_hold_write | (delta_now != 4'h0);
    end
  end

endmodule // uisl_channel

// Two channels and the shared oscillator gate.
// Assumes the clock gate itself sits outside; osc_run only asks for the stop.
module uisl_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        chip_select_n,
  input  wire        channel_select,
  input  wire [2:0]  addr,
  input  wire        wr_strobe,
  input  wire        rd_strobe,
  input  wire [7:0]  wr_data,
  output reg  [7:0]  rd_data,
  input  wire [1:0]  baud_tick16,
  input  wire [1:0]  tx_shift_out,
  input  wire [1:0]  rx_pin,
  input  wire [7:0]  modem_in_n,
  input  wire [15:0] rx_hold_byte,
  input  wire [15:0] fifo_level,
  input  wire [15:0] line_status_in,
  input  wire [15:0] status_in,
  output wire [1:0]  tx_pin,
  output wire [1:0]  rts_n,
  output wire [1:0]  dtr_n,
  output wire [1:0]  rx_shift_in,
  output wire [1:0]  tx_hold_write,
  output wire [1:0]  rx_hold_read,
  output wire [1:0]  fifo_ctrl_write,
  output wire [15:0] tx_hold_data,
  output wire [15:0] modem_status,
  output wire [15:0] divisor_word_a,
  output wire [15:0] divisor_word_b,
  output reg         osc_run
);
  wire [15:0] ch_rd;
  wire [1:0]  vote;
  wire [1:0]  wake;
  wire [15:0] div_low;
  wire [15:0] div_high;
  // ----------------------------------------------------------------
  // Channel instances
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      uisl_channel u_ch (
        .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
        .channel_select(channel_select), .my_channel(g == 1), .addr(addr),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_data(wr_data),
        .rd_data(ch_rd[g*8 +: 8]), .tx_hold_write(tx_hold_write[g]),
        .rx_hold_read(rx_hold_read[g]), .fifo_ctrl_write(fifo_ctrl_write[g]),
        .tx_hold_data(tx_hold_data[g*8 +: 8]), .rx_hold_byte(rx_hold_byte[g*8 +: 8]),
        .fifo_level(fifo_level[g*8 +: 8]), .line_status_in(line_status_in[g*8 +: 8]),
        .status_in(status_in[g*8 +: 8]), .baud_tick16(baud_tick16[g]),
        .tx_shift_out(tx_shift_out[g]), .rx_pin(rx_pin[g]), .modem_in_n(modem_in_n[g*4 +: 4]),
        .tx_pin(tx_pin[g]), .rts_n(rts_n[g]), .dtr_n(dtr_n[g]), .rx_shift_in(rx_shift_in[g]),
        .modem_status(modem_status[g*8 +: 8]),
        .divisor_low_byte(div_low[g*8 +: 8]),
        .divisor_high_byte(div_high[g*8 +: 8]),
        .sleep_vote(vote[g]), .wake_event(wake[g])
      );
    end
  endgenerate

  // Divisor words {high, low} per channel
  assign divisor_word_a = {div_high[7:0], div_low[7:0]};
  assign divisor_word_b = {div_high[15:8], div_low[15:8]};

  // Oscillator runs unless both channels vote sleep and nothing wakes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_run <= 1'b1;
      rd_data <= 8'h00;
    end else begin
      osc_run <= ~(&vote) | (|wake);
      rd_data <= ch_rd[7:0] | ch_rd[15:8];
    end
  end
endmodule // uisl_top

// [logic/uisl_regs.vh]
// Register offsets, field positions and reset values of the mode and map logic.
// Assumes inclusion by the channel module; definitions only.
`ifndef UISL_REGS_VH
`define UISL_REGS_VH
`define UISL_OFS_DATA      3'h0
`define UISL_OFS_IER       3'h1
`define UISL_OFS_ISR       3'h2
`define UISL_OFS_LCR       3'h3
`define UISL_OFS_MCR       3'h4
`define UISL_OFS_LSR       3'h5
`define UISL_OFS_MSR       3'h6
`define UISL_OFS_SPR       3'h7
`define UISL_ENH_PAGE      8'hbf
`define UISL_LCR_DIV_BIT   7
`define UISL_MCR_IR_BIT    6
`define UISL_MCR_LOOP_BIT  4
`define UISL_MCR_RTS_BIT   1
`define UISL_MCR_DTR_BIT   0
`define UISL_IER_SLEEP_BIT 4
`define UISL_FEATURE_CONTROL_INV_BIT  2
`define UISL_FEATURE_CONTROL_EMS_BIT  6
`define UISL_EFR_ENH_BIT   4
`define UISL_IER_ENH_MASK  8'hf0
`define UISL_MCR_ENH_MASK  8'he0
`define UISL_RST_BYTE      8'h00
`define UISL_RST_LCR       8'h03
`define UISL_RST_ISR       8'h01
`define UISL_RST_DLL       8'h01
`define UISL_IR_PULSE      4'h3
`define UISL_TICKS_BIT     4'hf
`endif
